// [pkg/hsc_pkg.sv]
// Constants for the host system control register bank
`default_nettype none
package hsc_pkg;
   // Clock and EEPROM serial timing
   localparam int CLK_MHZ = 10;
   localparam int EE_HALF_NS = 1000;
   localparam int EE_HALF_CYC = (EE_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int EE_CMD_BITS = 9;
   localparam int EE_DATA_BITS = 16;
   localparam int EE_WORDS = 3;
   localparam logic [2:0] EE_CMD_READ = 3'h6;
   // Strap sampling delay after reset release
   localparam logic [1:0] BOOT_WAIT = 2'h3;
   // Register offsets inside a bank
   localparam logic [3:0] OFF_SPEED = 4'h0;
   localparam logic [3:0] OFF_EEPROM_PIN_CTRL = 4'h2;
   localparam logic [3:0] OFF_STAT = 4'h4;
   localparam logic [3:0] OFF_GRR = 4'h6;
   localparam logic [3:0] OFF_BUS_WIDTH_CONFIG = 4'h8;
   localparam logic [3:0] OFF_STATION_ADDR_HIGH = 4'h4;
   localparam logic [3:0] OFF_BANK = 4'he;
   // Banks
   localparam logic [5:0] BANK_MAC = 6'h02;
   localparam logic [5:0] BANK_SYS = 6'h03;
   localparam logic [5:0] BANK_RSV_LO = 6'h04;
   localparam logic [5:0] BANK_RSV_HI = 6'h0f;
   // Base address
   localparam logic [15:0] BASE_DEFAULT = 16'h0300;
   localparam logic [15:0] BASE_MASK = 16'hffe0;
   // EEPROM word locations
   localparam logic [5:0] EE_WORD_BASE = 6'h00;
   localparam logic [5:0] EE_WORD_STATION_ADDR_HIGH = 6'h03;
   localparam logic [5:0] EE_WORD_CFG = 6'h06;
   // Field positions
   localparam int BIT_EEPROM_SOFTWARE_ACCESS = 4;
   localparam int BIT_EEPROM_SERIAL_IN = 3;
   localparam int BIT_TX_DONE = 12;
   localparam int BIT_TX_FAIL = 11;
   localparam int BIT_RX_DONE = 4;
   localparam int BIT_RX_FAIL = 3;
   localparam int BIT_CFG_SPEED = 1;
   localparam int BIT_CFG_WIDTH = 0;
   localparam int BIT_GRR = 0;
   // Bus speed codes
   localparam logic [1:0] SPEED_FAST = 2'h0;
   localparam logic [1:0] SPEED_SLOW = 2'h3;
   typedef enum logic [2:0] {
      HSC_LD_IDLE, HSC_LD_SEL, HSC_LD_OUT, HSC_LD_IN, HSC_LD_GAP, HSC_LD_DONE
   } hsc_ld_state_t;
endpackage
`default_nettype wire

// [hdl/hsc_eeprom_loader.sv]
// Serial EEPROM reader that fetches the boot words after reset
`default_nettype none
module hsc_eeprom_loader (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic start_i,
   input wire logic din_i,
   // EEPROM pins
   output logic cs_o,
   output logic sk_o,
   output logic do_o,
   // Loaded words
   output logic valid_o,
   output logic [5:0] addr_o,
   output logic [15:0] word_o,
   output logic busy_o
);
   import hsc_pkg::*;

   typedef struct packed {
      hsc_ld_state_t st;
      logic [3:0] tick;
      logic [4:0] bits;
      logic [1:0] widx;
      logic [8:0] cmd;
      logic [15:0] word;
      logic [5:0] addr;
      logic cs;
      logic sk;
      logic dout;
      logic valid;
   } hsc_ld_t;

   hsc_ld_t q;
   hsc_ld_t d;
   logic tick_end;

   function automatic logic [5:0] word_addr(input logic [1:0] idx);
      case (idx)
         2'h0: word_addr = EE_WORD_BASE;
         2'h1: word_addr = EE_WORD_STATION_ADDR_HIGH;
         default: word_addr = EE_WORD_CFG;
      endcase
   endfunction

   function automatic logic [8:0] read_cmd(input logic [1:0] idx);
      read_cmd = {EE_CMD_READ, word_addr(idx)};
   endfunction

   assign tick_end = (q.tick == 4'(EE_HALF_CYC - 1));

   always_comb begin
      d = q;
      d.valid = 1'b0;
      if (q.st != HSC_LD_IDLE && q.st != HSC_LD_DONE) begin
         d.tick = tick_end ? 4'h0 : q.tick + 4'h1;
      end
      case (q.st)
         HSC_LD_IDLE: begin
            if (start_i) begin
               d.st = HSC_LD_SEL;
               d.widx = 2'h0;
               d.cs = 1'b1;
               d.tick = 4'h0;
               d.cmd = read_cmd(2'h0);
            end
         end
         HSC_LD_SEL: begin
            if (tick_end) begin
               d.st = HSC_LD_OUT;
               d.bits = 5'h0;
               d.dout = q.cmd[8];
            end
         end
         HSC_LD_OUT: begin
            if (tick_end) begin
               if (!q.sk) begin
                  d.sk = 1'b1;
               end else begin
                  d.sk = 1'b0;
                  d.cmd = {q.cmd[7:0], 1'b0};
                  if (q.bits == 5'(EE_CMD_BITS - 1)) begin
                     d.st = HSC_LD_IN;
                     d.bits = 5'h0;
                     d.dout = 1'b0;
                  end else begin
                     d.bits = q.bits + 5'h1;
                     d.dout = q.cmd[7];
                  end
               end
            end
         end
         HSC_LD_IN: begin
            if (tick_end) begin
               if (!q.sk) begin
                  d.sk = 1'b1;
               end else begin
                  d.sk = 1'b0;
                  d.word = {q.word[14:0], din_i};
                  d.bits = q.bits + 5'h1;
                  if (q.bits == 5'(EE_DATA_BITS - 1)) begin
                     d.st = HSC_LD_GAP;
                     d.cs = 1'b0;
                     d.valid = 1'b1;
                     d.addr = word_addr(q.widx);
                  end
               end
            end
         end
         HSC_LD_GAP: begin
            // Chip select stays low for one half period between words
            if (tick_end) begin
               if (q.widx == 2'(EE_WORDS - 1)) begin
                  d.st = HSC_LD_DONE;
               end else begin
                  d.st = HSC_LD_SEL;
                  d.widx = q.widx + 2'h1;
                  d.cs = 1'b1;
                  d.cmd = read_cmd(q.widx + 2'h1);
               end
            end
         end
         default: begin
            d.st = HSC_LD_DONE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign cs_o = q.cs;
   assign sk_o = q.sk;
   assign do_o = q.dout;
   assign valid_o = q.valid;
   assign addr_o = q.addr;
   assign word_o = q.word;
   assign busy_o = (q.st != HSC_LD_IDLE) && (q.st != HSC_LD_DONE);
endmodule
`default_nettype wire

// [hdl/hsc_sysctl_regs.sv]
// Host system control registers: station address, bus speed, EEPROM pins, reset, config
`default_nettype none
module hsc_sysctl_regs (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Host register port
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic [3:0] bus_addr_i,
   input wire logic [15:0] bus_wdata_i,
   output logic [15:0] bus_rdata_o,
   output logic bus_rvalid_o,
   // Self-test status from memory test logic
   input wire logic tx_selftest_done_i,
   input wire logic tx_selftest_fail_i,
   input wire logic rx_selftest_done_i,
   input wire logic rx_selftest_fail_i,
   // EEPROM pins
   input wire logic eeprom_enable_pin_i,
   input wire logic eeprom_serial_in_i,
   output logic eeprom_serial_out_o,
   output logic eeprom_serial_clock_o,
   output logic eeprom_chip_select_o,
   // Control outputs to the rest of the chip
   output logic [1:0] internal_bus_speed_o,
   output logic [15:0] base_addr_o,
   output logic [15:0] station_addr_high_o,
   output logic soft_reset_o,
   output logic bus_width_16_o,
   output logic [5:0] bank_select_o
);
   import hsc_pkg::*;

   typedef struct packed {
      logic en_m;
      logic en_s;
      logic di_m;
      logic di_s;
      logic [1:0] boot;
      logic strap;
      logic ld_start;
      logic [5:0] bank;
      logic [15:0] base;
      logic [15:0] station_addr_high;
      logic [1:0] speed;
      logic eeprom_software_access;
      logic [2:0] eeprom_pin_bits;
      logic global_soft_reset;
      logic width;
      logic [15:0] rdata;
      logic rvalid;
      logic cs;
      logic sk;
      logic dout;
   } hsc_regs_t;

   hsc_regs_t q;
   hsc_regs_t d;
   logic ld_cs;
   logic ld_sk;
   logic ld_do;
   logic ld_valid;
   logic [5:0] ld_addr;
   logic [15:0] ld_word;
   logic ld_busy;

   function automatic logic hit(input logic [5:0] bank, input logic [3:0] addr,
                                input logic [5:0] want_bank, input logic [3:0] want_addr);
      hit = (bank == want_bank) && (addr == want_addr);
   endfunction

   hsc_eeprom_loader u_loader (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(q.ld_start),
      .din_i(q.di_s),
      .cs_o(ld_cs),
      .sk_o(ld_sk),
      .do_o(ld_do),
      .valid_o(ld_valid),
      .addr_o(ld_addr),
      .word_o(ld_word),
      .busy_o(ld_busy)
   );

   always_comb begin
      d = q;
      d.en_m = eeprom_enable_pin_i;
      d.en_s = q.en_m;
      d.di_m = eeprom_serial_in_i;
      d.di_s = q.di_m;
      d.ld_start = 1'b0;
      d.rvalid = 1'b0;
      // Strap is sampled once the synchroniser has settled after reset
      if (q.boot != BOOT_WAIT) begin
         d.boot = q.boot + 2'h1;
         if (q.boot == BOOT_WAIT - 2'h1) begin
            d.strap = q.en_s;
            d.ld_start = q.en_s;
         end
      end
      // Host writes
      // reserved banks ignore writes except to the bank select offset
      if (bus_wr_i) begin
         if (bus_addr_i == OFF_BANK) begin
            d.bank = bus_wdata_i[5:0];
         end else if (hit(q.bank, bus_addr_i, BANK_MAC, OFF_STATION_ADDR_HIGH)) begin
            d.station_addr_high = bus_wdata_i;
         end else if (hit(q.bank, bus_addr_i, BANK_SYS, OFF_SPEED)) begin
            d.speed = bus_wdata_i[1:0];
         end else if (hit(q.bank, bus_addr_i, BANK_SYS, OFF_EEPROM_PIN_CTRL)) begin
            d.eeprom_software_access = bus_wdata_i[BIT_EEPROM_SOFTWARE_ACCESS];
            d.eeprom_pin_bits = bus_wdata_i[2:0];
         end else if (hit(q.bank, bus_addr_i, BANK_SYS, OFF_GRR)) begin
            d.global_soft_reset = bus_wdata_i[BIT_GRR];
         end
      end
      // Loaded EEPROM words take priority over a host write in the same cycle
      if (ld_valid) begin
         if (ld_addr == EE_WORD_BASE) begin
            d.base = ld_word & BASE_MASK;
         end else if (ld_addr == EE_WORD_STATION_ADDR_HIGH) begin
            d.station_addr_high = ld_word;
         end else if (ld_addr == EE_WORD_CFG) begin
            d.speed = ld_word[BIT_CFG_SPEED] ? SPEED_SLOW : SPEED_FAST;
            d.width = ld_word[BIT_CFG_WIDTH];
         end
      end
      // Host reads; unmapped and reserved locations read zero
      // reserved banks read zero except at the bank select offset
      if (bus_rd_i) begin
         d.rvalid = 1'b1;
         d.rdata = 16'h0000;
         if (bus_addr_i == OFF_BANK) begin
            d.rdata[5:0] = q.bank;
         end else if (hit(q.bank, bus_addr_i, BANK_MAC, OFF_STATION_ADDR_HIGH)) begin
            d.rdata = q.station_addr_high;
         end else if (hit(q.bank, bus_addr_i, BANK_SYS, OFF_SPEED)) begin
            d.rdata[1:0] = q.speed;
         end else if (hit(q.bank, bus_addr_i, BANK_SYS, OFF_EEPROM_PIN_CTRL)) begin
            d.rdata[BIT_EEPROM_SOFTWARE_ACCESS] = q.eeprom_software_access;
            d.rdata[BIT_EEPROM_SERIAL_IN] = q.di_s;
            d.rdata[2:0] = q.eeprom_pin_bits;
         end else if (hit(q.bank, bus_addr_i, BANK_SYS, OFF_STAT)) begin
            d.rdata[BIT_TX_DONE] = tx_selftest_done_i;
            d.rdata[BIT_TX_FAIL] = tx_selftest_fail_i;
            d.rdata[BIT_RX_DONE] = rx_selftest_done_i;
            d.rdata[BIT_RX_FAIL] = rx_selftest_fail_i;
         end else if (hit(q.bank, bus_addr_i, BANK_SYS, OFF_GRR)) begin
            d.rdata[BIT_GRR] = q.global_soft_reset;
         end else if (hit(q.bank, bus_addr_i, BANK_SYS, OFF_BUS_WIDTH_CONFIG)) begin
            d.rdata[BIT_CFG_WIDTH] = q.width;
         end
      end
      if (q.eeprom_software_access) begin
         d.cs = q.eeprom_pin_bits[0];
         d.sk = q.eeprom_pin_bits[1];
         d.dout = q.eeprom_pin_bits[2];
      end else begin
         d.cs = ld_cs;
         d.sk = ld_sk;
         d.dout = ld_do;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // speed, pin bits and reset bit clear
         q <= '0;
         q.base <= BASE_DEFAULT;
      end else begin
         q <= d;
      end
   end

   assign bus_rdata_o = q.rdata;
   assign bus_rvalid_o = q.rvalid;
   assign eeprom_serial_out_o = q.dout;
   assign eeprom_serial_clock_o = q.sk;
   assign eeprom_chip_select_o = q.cs;
   assign internal_bus_speed_o = q.speed;
   assign base_addr_o = q.base;
   assign station_addr_high_o = q.station_addr_high;
   assign soft_reset_o = q.global_soft_reset;
   assign bus_width_16_o = q.width;
   assign bank_select_o = q.bank;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_station_addr_high_write;
      bus_wr_i && !ld_valid && hit(q.bank, bus_addr_i, BANK_MAC, OFF_STATION_ADDR_HIGH)
         |=> station_addr_high_o == $past(bus_wdata_i);
   endproperty
   a_station_addr_high_write: assert property (p_station_addr_high_write) else $error("high address write lost");

   property p_reset_values;
      $fell(rst_i) |-> internal_bus_speed_o == SPEED_FAST && base_addr_o == BASE_DEFAULT
         && !soft_reset_o && !q.eeprom_pin_bits[0] && !q.eeprom_pin_bits[1] && !q.eeprom_pin_bits[2];
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("bad reset values");

   property p_speed_preset;
      ld_valid && ld_addr == EE_WORD_CFG
         |=> internal_bus_speed_o == ($past(ld_word[BIT_CFG_SPEED]) ? SPEED_SLOW : SPEED_FAST);
   endproperty
   a_speed_preset: assert property (p_speed_preset) else $error("speed preset wrong");

   property p_speed_write;
      bus_wr_i && !ld_valid && hit(q.bank, bus_addr_i, BANK_SYS, OFF_SPEED)
         |=> internal_bus_speed_o == $past(bus_wdata_i[1:0]);
   endproperty
   a_speed_write: assert property (p_speed_write) else $error("speed write lost");

   property p_eeprom_serial_in_read;
      bus_rd_i && hit(q.bank, bus_addr_i, BANK_SYS, OFF_EEPROM_PIN_CTRL)
         |=> bus_rvalid_o && bus_rdata_o[BIT_EEPROM_SERIAL_IN] == $past(q.di_s);
   endproperty
   a_eeprom_serial_in_read: assert property (p_eeprom_serial_in_read) else $error("serial input readback wrong");

   property p_sw_pins;
      q.eeprom_software_access ##1 q.eeprom_software_access |-> eeprom_chip_select_o == $past(q.eeprom_pin_bits[0])
         && eeprom_serial_clock_o == $past(q.eeprom_pin_bits[1]) && eeprom_serial_out_o == $past(q.eeprom_pin_bits[2]);
   endproperty
   a_sw_pins: assert property (p_sw_pins) else $error("pins not following bits");

   property p_loader_pins;
      !q.eeprom_software_access |=> eeprom_chip_select_o == $past(ld_cs) && eeprom_serial_clock_o == $past(ld_sk);
   endproperty
   a_loader_pins: assert property (p_loader_pins) else $error("loader lost pins");

   property p_soft_reset;
      bus_wr_i && hit(q.bank, bus_addr_i, BANK_SYS, OFF_GRR)
         |=> soft_reset_o == $past(bus_wdata_i[BIT_GRR]);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset not set");

   property p_bank_sel;
      bus_wr_i && bus_addr_i == OFF_BANK |=> bank_select_o == $past(bus_wdata_i[5:0]);
   endproperty
   a_bank_sel: assert property (p_bank_sel) else $error("bank select write lost");

   property p_reserved_bank;
      bus_rd_i && q.bank >= BANK_RSV_LO && q.bank <= BANK_RSV_HI && bus_addr_i != OFF_BANK
         |=> bus_rdata_o == 16'h0000;
   endproperty
   a_reserved_bank: assert property (p_reserved_bank) else $error("reserved bank not zero");

   property p_width_load;
      ld_valid && ld_addr == EE_WORD_CFG |=> bus_width_16_o == $past(ld_word[BIT_CFG_WIDTH]);
   endproperty
   a_width_load: assert property (p_width_load) else $error("width bit not loaded");

   property p_no_strap_no_load;
      !q.strap && q.boot == BOOT_WAIT |-> !ld_busy && !ld_valid;
   endproperty
   a_no_strap_no_load: assert property (p_no_strap_no_load) else $error("load without strap");

   property p_load_start;
      q.boot == BOOT_WAIT - 2'h1 && q.en_s |-> ##2 ld_busy;
   endproperty
   a_load_start: assert property (p_load_start) else $error("loader not started");

   property p_base_load;
      ld_valid && ld_addr == EE_WORD_BASE |=> base_addr_o == ($past(ld_word) & BASE_MASK);
   endproperty
   a_base_load: assert property (p_base_load) else $error("base not loaded");

   property p_station_addr_high_load;
      ld_valid && ld_addr == EE_WORD_STATION_ADDR_HIGH |=> station_addr_high_o == $past(ld_word);
   endproperty
   a_station_addr_high_load: assert property (p_station_addr_high_load) else $error("high word not loaded");

   property p_speed_hold;
      !bus_wr_i && !ld_valid |=> $stable(internal_bus_speed_o);
   endproperty
   a_speed_hold: assert property (p_speed_hold) else $error("speed changed alone");

   property p_eeprom_pin_ctrl_write;
      bus_wr_i && hit(q.bank, bus_addr_i, BANK_SYS, OFF_EEPROM_PIN_CTRL)
         |=> q.eeprom_software_access == $past(bus_wdata_i[BIT_EEPROM_SOFTWARE_ACCESS]) && q.eeprom_pin_bits == $past(bus_wdata_i[2:0]);
   endproperty
   a_eeprom_pin_ctrl_write: assert property (p_eeprom_pin_ctrl_write) else $error("pin control write lost");

   property p_tx_status;
      bus_rd_i && hit(q.bank, bus_addr_i, BANK_SYS, OFF_STAT)
         |=> bus_rdata_o[BIT_TX_DONE] == $past(tx_selftest_done_i)
         && bus_rdata_o[BIT_TX_FAIL] == $past(tx_selftest_fail_i);
   endproperty
   a_tx_status: assert property (p_tx_status) else $error("transmit status wrong");

   property p_rx_status;
      bus_rd_i && hit(q.bank, bus_addr_i, BANK_SYS, OFF_STAT)
         |=> bus_rdata_o[BIT_RX_DONE] == $past(rx_selftest_done_i)
         && bus_rdata_o[BIT_RX_FAIL] == $past(rx_selftest_fail_i);
   endproperty
   a_rx_status: assert property (p_rx_status) else $error("receive status wrong");

   c_load_cfg: cover property (ld_valid && ld_addr == EE_WORD_CFG);
   c_sw_access: cover property (q.eeprom_software_access && eeprom_serial_clock_o);
   c_soft_reset: cover property (soft_reset_o ##1 !soft_reset_o);
   c_status_read: cover property (bus_rd_i && hit(q.bank, bus_addr_i, BANK_SYS, OFF_STAT));
endmodule
`default_nettype wire

// [verif/hsc_eeprom_model.sv]
// Behavioural serial configuration memory answering read commands
`default_nettype none
module hsc_eeprom_model (
   // Memory pins
   input wire logic cs_i,
   input wire logic sk_i,
   input wire logic di_i,
   output logic do_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [64];
   logic [8:0] cmd;
   logic [15:0] sh;
   int cnt;
   initial begin
      do_o = 1'b0;
      cnt = 0;
      cmd = 9'h0;
   end
   // Deselected output is undriven: show the inverse of the last bit
   // Power-up settling of the select line is not a release
   always @(negedge cs_i) begin
      if (cnt != 0) begin
         do_o <= ~do_o;
      end
   end
   always @(posedge cs_i) begin
      cnt = 0;
   end
   // Command shifted in MSB first, data shifted out MSB first
   always @(posedge sk_i) begin
      if (cs_i) begin
         if (cnt < 9) begin
            cmd = {cmd[7:0], di_i};
         end
         if (cnt == 8) begin
            sh = mem[cmd[5:0]];
         end
         if (cnt >= 9 && cnt < 25 && cmd[8:6] == 3'h6) begin
            do_o <= sh[15];
            sh = {sh[14:0], 1'b0};
         end else if (cnt >= 9) begin
            do_o <= ~do_o;
         end
         cnt = cnt + 1;
      end
   end
endmodule
`default_nettype wire

// [verif/test_hsc_sysctl_regs.sv]
// Self-checking bench for the host system control register bank
`default_nettype none
module test_hsc_sysctl_regs;
   timeunit 1ns;
   timeprecision 100ps;
   import hsc_pkg::*;
   logic clk_i, rst_i, bus_wr_i, bus_rd_i, bus_rvalid_o, txd, txf, rxd, rxf, strap;
   logic ee_in, ee_out, ee_sk, ee_cs, soft_reset_o, bw16, seen;
   logic [3:0] bus_addr_i;
   logic [15:0] bus_wdata_i, bus_rdata_o, base, sah, w0, w3, w5, v;
   logic [1:0] speed;
   logic [5:0] bank;
   logic [5:0] rsv [4] = '{6'h01, 6'h04, 6'h09, 6'h0f};
   logic [15:0] expq [$];
   int errors = 0;
   int n_compared = 0;

   hsc_sysctl_regs i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
      .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
      .bus_rvalid_o(bus_rvalid_o), .tx_selftest_done_i(txd), .tx_selftest_fail_i(txf),
      .rx_selftest_done_i(rxd), .rx_selftest_fail_i(rxf), .eeprom_enable_pin_i(strap),
      .eeprom_serial_in_i(ee_in), .eeprom_serial_out_o(ee_out),
      .eeprom_serial_clock_o(ee_sk), .eeprom_chip_select_o(ee_cs),
      .internal_bus_speed_o(speed), .base_addr_o(base), .station_addr_high_o(sah),
      .soft_reset_o(soft_reset_o), .bus_width_16_o(bw16), .bank_select_o(bank));
   hsc_eeprom_model i_ee (.cs_i(ee_cs), .sk_i(ee_sk), .di_i(ee_out), .do_o(ee_in));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task automatic test_done;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cmp_out(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
      cmp_out(got, exp, "read data");
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      bus_wr_i <= 1'b1;
      bus_addr_i <= a;
      bus_wdata_i <= d;
      @(posedge clk_i);
      bus_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      expq.push_back(e);
      @(posedge clk_i);
      bus_rd_i <= 1'b1;
      bus_addr_i <= a;
      @(posedge clk_i);
      bus_rd_i <= 1'b0;
   endtask
   task automatic settle;
      repeat (3) @(posedge clk_i);
      #10;
   endtask
   task automatic pins(input logic [2:0] e);
      settle;
      cmp_out({13'h0, ee_out, ee_sk, ee_cs}, {13'h0, e}, "pins");
   endtask
   task automatic boot(input logic s);
      @(posedge clk_i);
      rst_i <= 1'b1;
      strap <= s;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   // Wait for the boot load to finish; the width bit comes from the last word
   task automatic wait_load;
      seen = 1'b0;
      for (int n = 0; n < 3000 && bw16 !== 1'b1; n++) begin
         @(posedge clk_i);
         #10;
         seen = seen | ee_cs;
      end
      if (bw16 !== 1'b1) begin
         errors++;
         $display("BAD %0t configuration load never finished", $time);
         test_done;
      end
      settle;
   endtask

   // Read answers are matched against the oldest noted expectation
   always @(posedge clk_i) begin
      if (bus_rvalid_o === 1'b1) begin
         if (expq.size() == 0) begin
            errors++;
            $display("BAD %0t unexpected read answer", $time);
         end else begin
            cmp_rd(bus_rdata_o, expq.pop_front());
         end
      end
   end

   initial begin
      logic [8:0] c;
      rst_i = 1'b1;
      bus_wr_i = 1'b0;
      bus_rd_i = 1'b0;
      bus_addr_i = 4'h0;
      bus_wdata_i = 16'h0;
      {txd, txf, rxd, rxf, strap} = 5'h0;
      void'($urandom(50));
      w0 = 16'($urandom());
      w3 = 16'($urandom());
      w5 = 16'($urandom());
      i_ee.mem[0] = w0;
      i_ee.mem[3] = w3;
      i_ee.mem[5] = w5;
      i_ee.mem[6] = 16'h0001;
      boot(1'b0);
      settle;
      cmp_out({14'h0, speed}, 16'h0000, "speed");
      cmp_out(base, BASE_DEFAULT, "base");
      cmp_out({15'h0, bw16}, 16'h0000, "width");
      pins(3'h0);
      wr(OFF_BANK, {10'h0, BANK_SYS});
      rd(OFF_EEPROM_PIN_CTRL, 16'h0000);
      rd(OFF_GRR, 16'h0000);
      rd(OFF_BUS_WIDTH_CONFIG, 16'h0000);
      rd(4'ha, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_SPEED, 16'(i) | 16'hfffc);
         settle;
         cmp_out({14'h0, speed}, 16'(i), "speed");
         rd(OFF_SPEED, 16'(i));
      end
      for (int i = 0; i < 6; i++) begin
         v = 16'($urandom());
         @(posedge clk_i);
         {txd, txf, rxd, rxf} <= v[3:0];
         wr(OFF_STAT, 16'hffff);
         rd(OFF_STAT, {3'h0, v[3], v[2], 6'h0, v[1], v[0], 3'h0});
      end
      v = 16'($urandom());
      wr(OFF_BANK, {10'h0, BANK_MAC});
      wr(OFF_STATION_ADDR_HIGH, v);
      settle;
      cmp_out(sah, v, "station");
      cmp_out({10'h0, bank}, {10'h0, BANK_MAC}, "bank");
      rd(OFF_STATION_ADDR_HIGH, v);
      rd(OFF_BANK, 16'h0002);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_BANK, {10'h0, rsv[i]});
         wr(OFF_SPEED, 16'h0001);
         wr(OFF_STATION_ADDR_HIGH, 16'h0000);
         rd(OFF_SPEED, 16'h0000);
         rd(OFF_BANK, {10'h0, rsv[i]});
      end
      settle;
      cmp_out({14'h0, speed}, 16'h0003, "speed");
      cmp_out(sah, v, "station");
      wr(OFF_BANK, {10'h0, BANK_SYS});
      wr(OFF_EEPROM_PIN_CTRL, 16'h0007);
      pins(3'h0);
      rd(OFF_EEPROM_PIN_CTRL, 16'h0007);
      wr(OFF_EEPROM_PIN_CTRL, 16'h0011);
      pins(3'h1);
      // software shifts out a read command
      c = {3'h6, 6'h05};
      for (int i = 8; i >= 0; i--) begin
         wr(OFF_EEPROM_PIN_CTRL, {11'h0, 2'h2, c[i], 2'h1});
         wr(OFF_EEPROM_PIN_CTRL, {11'h0, 2'h2, c[i], 2'h3});
         pins({c[i], 2'h3});
      end
      for (int k = 15; k >= 0; k--) begin
         wr(OFF_EEPROM_PIN_CTRL, 16'h0011);
         wr(OFF_EEPROM_PIN_CTRL, 16'h0013);
         settle;
         rd(OFF_EEPROM_PIN_CTRL, {12'h001, w5[k], 3'h3});
      end
      wr(OFF_EEPROM_PIN_CTRL, 16'h0000);
      pins(3'h0);
      boot(1'b1);
      wait_load;
      cmp_out({15'h0, seen}, 16'h0001, "loader select");
      cmp_out({14'h0, speed}, 16'h0000, "speed");
      i_ee.mem[6] = 16'h0003;
      boot(1'b1);
      wait_load;
      cmp_out(base, w0 & BASE_MASK, "base");
      cmp_out(sah, w3, "station");
      cmp_out({15'h0, bw16}, 16'h0001, "width");
      cmp_out({14'h0, speed}, 16'h0003, "speed");
      wr(OFF_BANK, {10'h0, BANK_SYS});
      rd(OFF_BUS_WIDTH_CONFIG, 16'h0001);
      wr(OFF_SPEED, 16'h0001);
      rd(OFF_SPEED, 16'h0001);
      // soft reset is set and then cleared
      wr(OFF_GRR, 16'h0001);
      settle;
      cmp_out({15'h0, soft_reset_o}, 16'h0001, "soft reset");
      cmp_out(base, w0 & BASE_MASK, "base");
      rd(OFF_GRR, 16'h0001);
      wr(OFF_GRR, 16'h0000);
      settle;
      cmp_out({15'h0, soft_reset_o}, 16'h0000, "soft reset");
      repeat (4) @(posedge clk_i);
      cmp_out(16'(expq.size()), 16'h0000, "unanswered reads");
      test_done;
   end
endmodule
`default_nettype wire
